//--- core/sci_pkg.sv
// shared constants, types and register map of the spindle command interlock
package sci_pkg;

    // ------------------------------------------------------------------
    // register map (byte addresses) and bus answers
    // ------------------------------------------------------------------
    localparam int unsigned ADDR_W        = 8;
    localparam logic [7:0]  OFF_CFG_A     = 8'h00;
    localparam logic [7:0]  OFF_CFG_B     = 8'h04;
    localparam logic [7:0]  OFF_OPTIONS   = 8'h08;
    localparam logic [7:0]  OFF_STATUS    = 8'h0c;
    localparam logic [7:0]  OFF_IRQ_STAT  = 8'h10;
    localparam logic [7:0]  OFF_IRQ_MASK  = 8'h14;
    localparam logic [1:0]  RESP_OKAY     = 2'h0;
    localparam logic [1:0]  RESP_SLVERR   = 2'h2;

    // ------------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------------
    localparam logic [7:0]  P4001_RST     = 8'h00;
    localparam logic [7:0]  P4011_RST     = 8'h01;
    localparam logic [7:0]  P4018_RST     = 8'h00;
    localparam logic [1:0]  OPT_RST       = 2'h0;
    localparam logic [2:0]  IRQ_RST       = 3'h0;

    // ------------------------------------------------------------------
    // configuration field positions
    // ------------------------------------------------------------------
    localparam int unsigned P4001_MACHINE_READY_IN_USE  = 0;
    localparam int unsigned P4001_POS_CODER = 2;
    localparam int unsigned P4001_HRES_LO   = 5;
    localparam int unsigned P4001_HRES_HI   = 6;
    localparam logic [1:0]  HRES_SEL        = 2'h1;
    localparam int unsigned P4011_DET_LSB   = 0;
    localparam int unsigned P4011_DET_W     = 3;
    localparam logic [2:0]  DET_128_REV     = 3'h1;
    localparam int unsigned P4018_SENSOR_CS = 4;
    localparam int unsigned OPT_ORIENT      = 0;
    localparam int unsigned OPT_OUT_SWITCH  = 1;
    localparam int unsigned CFG_B_P4018_LSB = 8;

    // status register fields
    localparam int unsigned ST_CODE_LSB   = 0;
    localparam int unsigned ST_YELLOW     = 8;
    localparam int unsigned ST_RED        = 9;
    localparam int unsigned ST_EXCITE     = 10;
    localparam int unsigned ST_MODE_LSB   = 12;
    localparam int unsigned ST_ALARM_LSB  = 16;

    // interrupt events
    localparam int unsigned IRQ_W         = 3;
    localparam int unsigned IRQ_ERR_SET   = 0;
    localparam int unsigned IRQ_ALARM_SET = 1;
    localparam int unsigned IRQ_ERR_CLR   = 2;

    // ------------------------------------------------------------------
    // error codes: index into the hit vector, shown as two bcd digits
    // ------------------------------------------------------------------
    localparam int unsigned NUM_CODES     = 13;
    localparam int unsigned IDX_UNUSED    = 8;
    localparam logic [7:0]  CODE_NONE     = 8'hff;
    localparam logic [7:0]  CODE_BCD [NUM_CODES] = '{
        8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06,
        8'h07, 8'h08, 8'h09, 8'h10, 8'h11, 8'h12};
    localparam logic [7:0]  DISP_BLANK    = 8'h00;
    localparam logic [7:0]  ALARM_NONE    = 8'h00;

    // ------------------------------------------------------------------
    // types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        MD_NORMAL, MD_CONTOUR, MD_SERVO, MD_SYNC
    } sci_mode_e;

    typedef struct packed {
        logic esp_ok;
        logic machine_ready_in;
        logic fwd;
        logic rev;
        logic orient;
        logic low_wind;
        logic contour;
        logic servo;
        logic sync;
    } sci_req_s;

    typedef struct packed {
        logic [7:0] p4001;
        logic [7:0] p4011;
        logic [7:0] p4018;
        logic [1:0] opt;
    } sci_cfg_s;

endpackage

//--- core/sci_sync.sv
// two-stage synchroniser bank for pin-level request inputs
`timescale 1ns/1ps
`default_nettype none

module sci_sync #(
    parameter int unsigned W = 9
) (
    input  wire logic         clk_i,
    input  wire logic         rst_n_i,
    input  wire logic         ce_i,
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);

    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;

    // ------------------------------------------------------------------
    // one two-flop chain per bit; first stage feeds only the second
    // ------------------------------------------------------------------
    for (genvar i = 0; i < W; i++) begin : g_bit
        always_ff @(posedge clk_i) begin
            if (!rst_n_i) begin
                meta_q[i] <= 1'b0;
                sync_q[i] <= 1'b0;
            end else if (ce_i) begin
                meta_q[i] <= d_i[i];
                sync_q[i] <= meta_q[i];
            end
        end
    end

    assign q_o = sync_q;

endmodule

`default_nettype wire

//--- core/sci_interlock.sv
// spindle command interlock: request checks, error display, axi4-lite registers
//
// Added by the designer: register access over AXI4-Lite and the address map.
`timescale 1ns/1ps
`default_nettype none

module sci_interlock (
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    input  wire logic        ce_i,
    input  wire logic        emergency_stop_release_n_i,
    input  wire logic        machine_ready_in_i,
    input  wire logic        forward_rotation_req_i,
    input  wire logic        reverse_rotation_req_i,
    input  wire logic        orientation_req_i,
    input  wire logic        low_speed_winding_sel_i,
    input  wire logic        contour_axis_req_i,
    input  wire logic        servo_mode_req_i,
    input  wire logic        spindle_sync_req_i,
    input  wire logic [7:0]  drive_alarm_i,
    output logic [7:0]       display_code_o,
    output logic             yellow_lamp_o,
    output logic             red_lamp_o,
    output logic             motor_excite_en_o,
    output logic             irq_o,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready
);

    // ------------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------------
    sci_pkg::sci_req_s              req;
    sci_pkg::sci_cfg_s              cfg_q, cfg_d;
    sci_pkg::sci_mode_e             mode_q, mode_d;
    logic [sci_pkg::NUM_CODES-1:0]  hit;
    logic                           run_req, rot_req;
    logic [7:0]                     code_q, code_d, alarm_q, disp_q, disp_d;
    logic                           yel_q, yel_d, red_q, red_d, exc_q, exc_d;
    logic [sci_pkg::IRQ_W-1:0]      ist_q, ist_d, imask_q, imask_d, ev;
    logic                           aw_q, aw_d, w_q, w_d, b_q, b_d, r_q, r_d;
    logic [7:0]                     awa_q, awa_d;
    logic [31:0]                    wd_q, wd_d, rd_q, rd_d;
    logic [3:0]                     ws_q, ws_d;
    logic [1:0]                     bresp_q, bresp_d, rresp_q, rresp_d;
    logic                           do_wr, do_rd;

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] nw, input logic en);
        merge = en ? nw : old;
    endfunction

    function automatic logic [7:0] first_code(input logic [sci_pkg::NUM_CODES-1:0] h);
        first_code = sci_pkg::CODE_NONE;
        for (int k = sci_pkg::NUM_CODES - 1; k >= 0; k--) begin
            if (h[k]) begin
                first_code = sci_pkg::CODE_BCD[k];
            end
        end
    endfunction

    // ------------------------------------------------------------------
    // request inputs come off pins: synchronise before use
    // ------------------------------------------------------------------
    sci_sync #(
        .W ($bits(sci_pkg::sci_req_s))
    ) u_sync (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .ce_i    (ce_i),
        .d_i     ({emergency_stop_release_n_i, machine_ready_in_i, forward_rotation_req_i,
                   reverse_rotation_req_i, orientation_req_i, low_speed_winding_sel_i,
                   contour_axis_req_i, servo_mode_req_i, spindle_sync_req_i}),
        .q_o     (req)
    );

    // ------------------------------------------------------------------
    // conflict checks, one bit per code
    // ------------------------------------------------------------------
    always_comb begin
        rot_req = req.fwd | req.rev;
        run_req = rot_req | req.orient;
        hit     = '0;
        hit[0]  = run_req & ~(req.esp_ok & (req.machine_ready_in | ~cfg_q.p4001[sci_pkg::P4001_MACHINE_READY_IN_USE]));
        hit[1]  = (cfg_q.p4001[sci_pkg::P4001_HRES_HI:sci_pkg::P4001_HRES_LO] == sci_pkg::HRES_SEL) &
                  (cfg_q.p4011[sci_pkg::P4011_DET_LSB +: sci_pkg::P4011_DET_W] != sci_pkg::DET_128_REV);
        hit[2]  = req.contour & ~cfg_q.p4001[sci_pkg::P4001_HRES_LO]
                  & ~cfg_q.p4018[sci_pkg::P4018_SENSOR_CS];
        hit[3]  = (req.servo | req.sync) & ~cfg_q.p4001[sci_pkg::P4001_POS_CODER];
        hit[4]  = req.orient & ~cfg_q.opt[sci_pkg::OPT_ORIENT];
        hit[5]  = req.low_wind & ~cfg_q.opt[sci_pkg::OPT_OUT_SWITCH];
        hit[6]  = req.contour & ~rot_req;
        hit[7]  = req.servo & ~rot_req;
        hit[9]  = req.sync & ~rot_req;
        hit[10] = (mode_q == sci_pkg::MD_CONTOUR) & (req.servo | req.sync | req.orient);
        hit[11] = (mode_q == sci_pkg::MD_SERVO) & (req.contour | req.sync | req.orient);
        hit[12] = (mode_q == sci_pkg::MD_SYNC) & (req.contour | req.servo | req.orient);
    end

    // ------------------------------------------------------------------
    // operating mode: entered only on a clean request, left on withdrawal
    // ------------------------------------------------------------------
    always_comb begin
        mode_d = mode_q;
        unique case (mode_q)
            sci_pkg::MD_NORMAL: begin
                if (hit == '0) begin
                    if (req.contour) begin
                        mode_d = sci_pkg::MD_CONTOUR;
                    end else if (req.servo) begin
                        mode_d = sci_pkg::MD_SERVO;
                    end else if (req.sync) begin
                        mode_d = sci_pkg::MD_SYNC;
                    end
                end
            end
            // leaving relies on the host dropping the active request
            sci_pkg::MD_CONTOUR: if (!req.contour) mode_d = sci_pkg::MD_NORMAL;
            sci_pkg::MD_SERVO:   if (!req.servo) mode_d = sci_pkg::MD_NORMAL;
            sci_pkg::MD_SYNC:    if (!req.sync) mode_d = sci_pkg::MD_NORMAL;
        endcase
    end

    // ------------------------------------------------------------------
    // display, lamps, excitation; lowest code wins, held while cause stays
    // ------------------------------------------------------------------
    always_comb begin
        code_d = first_code(hit);
        red_d  = (drive_alarm_i != sci_pkg::ALARM_NONE);
        yel_d  = ~red_d & (code_d != sci_pkg::CODE_NONE);
        // alarm outranks a setting error: lamp colour says which is shown
        disp_d = red_d ? drive_alarm_i : (yel_d ? code_d : sci_pkg::DISP_BLANK);
        exc_d  = ~(hit[1] | hit[2] | hit[3]);
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            mode_q  <= sci_pkg::MD_NORMAL;
            code_q  <= sci_pkg::CODE_NONE;
            alarm_q <= sci_pkg::ALARM_NONE;
            disp_q  <= sci_pkg::DISP_BLANK;
            yel_q   <= 1'b0;
            red_q   <= 1'b0;
            exc_q   <= 1'b0;
        end else if (ce_i) begin
            mode_q  <= mode_d;
            code_q  <= code_d;
            alarm_q <= drive_alarm_i;
            disp_q  <= disp_d;
            yel_q   <= yel_d;
            red_q   <= red_d;
            exc_q   <= exc_d;
        end
    end

    assign display_code_o    = disp_q;
    assign yellow_lamp_o     = yel_q;
    assign red_lamp_o        = red_q;
    assign motor_excite_en_o = exc_q;

    // ------------------------------------------------------------------
    // axi4-lite slave: one write and one read in flight
    // ------------------------------------------------------------------
    assign s_axi_awready = ce_i & ~aw_q & ~b_q;
    assign s_axi_wready  = ce_i & ~w_q & ~b_q;
    assign s_axi_arready = ce_i & ~r_q;
    assign s_axi_bvalid  = b_q;
    assign s_axi_bresp   = bresp_q;
    assign s_axi_rvalid  = r_q;
    assign s_axi_rdata   = rd_q;
    assign s_axi_rresp   = rresp_q;

    always_comb begin
        aw_d    = aw_q | (s_axi_awvalid & s_axi_awready);
        awa_d   = (s_axi_awvalid & s_axi_awready) ? s_axi_awaddr : awa_q;
        w_d     = w_q | (s_axi_wvalid & s_axi_wready);
        wd_d    = (s_axi_wvalid & s_axi_wready) ? s_axi_wdata : wd_q;
        ws_d    = (s_axi_wvalid & s_axi_wready) ? s_axi_wstrb : ws_q;
        do_wr   = aw_q & w_q & ~b_q;
        b_d     = b_q;
        bresp_d = bresp_q;
        cfg_d   = cfg_q;
        imask_d = imask_q;
        if (b_q & s_axi_bready) begin
            b_d = 1'b0;
        end
        if (do_wr) begin
            aw_d    = 1'b0;
            w_d     = 1'b0;
            b_d     = 1'b1;
            bresp_d = sci_pkg::RESP_OKAY;
            unique case (awa_q)
                sci_pkg::OFF_CFG_A: cfg_d.p4001 = merge(cfg_q.p4001, wd_q[7:0], ws_q[0]);
                sci_pkg::OFF_CFG_B: begin
                    cfg_d.p4011 = merge(cfg_q.p4011, wd_q[7:0], ws_q[0]);
                    cfg_d.p4018 = merge(cfg_q.p4018, wd_q[15:8], ws_q[1]);
                end
                sci_pkg::OFF_OPTIONS: if (ws_q[0]) cfg_d.opt = wd_q[1:0];
                sci_pkg::OFF_IRQ_MASK: if (ws_q[0]) imask_d = wd_q[sci_pkg::IRQ_W-1:0];
                sci_pkg::OFF_STATUS, sci_pkg::OFF_IRQ_STAT: bresp_d = sci_pkg::RESP_OKAY;
                default: bresp_d = sci_pkg::RESP_SLVERR;
            endcase
        end
    end

    // read data is captured at acceptance so a read-clear cannot lose its value
    always_comb begin
        do_rd   = s_axi_arvalid & s_axi_arready;
        r_d     = (r_q & ~s_axi_rready) | do_rd;
        rd_d    = rd_q;
        rresp_d = rresp_q;
        if (do_rd) begin
            rd_d    = '0;
            rresp_d = sci_pkg::RESP_OKAY;
            unique case (s_axi_araddr)
                sci_pkg::OFF_CFG_A:    rd_d[7:0] = cfg_q.p4001;
                sci_pkg::OFF_CFG_B:    rd_d[15:0] = {cfg_q.p4018, cfg_q.p4011};
                sci_pkg::OFF_OPTIONS:  rd_d[1:0] = cfg_q.opt;
                sci_pkg::OFF_STATUS: begin
                    rd_d[sci_pkg::ST_CODE_LSB +: 8]  = code_q;
                    rd_d[sci_pkg::ST_YELLOW]         = yel_q;
                    rd_d[sci_pkg::ST_RED]            = red_q;
                    rd_d[sci_pkg::ST_EXCITE]         = exc_q;
                    rd_d[sci_pkg::ST_MODE_LSB +: 2]  = mode_q;
                    rd_d[sci_pkg::ST_ALARM_LSB +: 8] = alarm_q;
                end
                sci_pkg::OFF_IRQ_STAT: rd_d[sci_pkg::IRQ_W-1:0] = ist_q;
                sci_pkg::OFF_IRQ_MASK: rd_d[sci_pkg::IRQ_W-1:0] = imask_q;
                default:               rresp_d = sci_pkg::RESP_SLVERR;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // interrupts: sticky events, cleared by reading, a new event wins
    // ------------------------------------------------------------------
    always_comb begin
        ev = '0;
        ev[sci_pkg::IRQ_ERR_SET]   = (code_d != sci_pkg::CODE_NONE) & (code_d != code_q);
        ev[sci_pkg::IRQ_ALARM_SET] = red_d & ~red_q;
        ev[sci_pkg::IRQ_ERR_CLR]   = (code_d == sci_pkg::CODE_NONE) & (code_q != sci_pkg::CODE_NONE);
        ist_d = ist_q;
        if (do_rd && s_axi_araddr == sci_pkg::OFF_IRQ_STAT) begin
            ist_d = '0;
        end
        ist_d = ist_d | ev;
    end

    assign irq_o = |(ist_q & imask_q);

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            cfg_q   <= '{sci_pkg::P4001_RST, sci_pkg::P4011_RST, sci_pkg::P4018_RST, sci_pkg::OPT_RST};
            imask_q <= sci_pkg::IRQ_RST;
            ist_q   <= sci_pkg::IRQ_RST;
            aw_q    <= 1'b0;
            w_q     <= 1'b0;
            b_q     <= 1'b0;
            r_q     <= 1'b0;
            awa_q   <= '0;
            wd_q    <= '0;
            ws_q    <= '0;
            rd_q    <= '0;
            bresp_q <= sci_pkg::RESP_OKAY;
            rresp_q <= sci_pkg::RESP_OKAY;
        end else if (ce_i) begin
            cfg_q   <= cfg_d;
            imask_q <= imask_d;
            ist_q   <= ist_d;
            aw_q    <= aw_d;
            w_q     <= w_d;
            b_q     <= b_d;
            r_q     <= r_d;
            awa_q   <= awa_d;
            wd_q    <= wd_d;
            ws_q    <= ws_d;
            rd_q    <= rd_d;
            bresp_q <= bresp_d;
            rresp_q <= rresp_d;
        end
    end

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    property p_yellow_shows_code;
        yellow_lamp_o |-> (display_code_o == code_q) && !red_lamp_o;
    endproperty
    a_yellow_shows_code: assert property (p_yellow_shows_code) else $error("yellow display mismatch");

    property p_red_shows_alarm;
        ce_i && drive_alarm_i != sci_pkg::ALARM_NONE |=> red_lamp_o && display_code_o == $past(drive_alarm_i);
    endproperty
    a_red_shows_alarm: assert property (p_red_shows_alarm) else $error("red alarm not shown");

    property p_stop_code;
        ce_i && run_req && !req.esp_ok |=> code_q == sci_pkg::CODE_BCD[0];
    endproperty
    a_stop_code: assert property (p_stop_code) else $error("code 00 missing");

    property p_ready_masked;
        ce_i && req.esp_ok && !cfg_q.p4001[sci_pkg::P4001_MACHINE_READY_IN_USE] |=> code_q != sci_pkg::CODE_BCD[0];
    endproperty
    a_ready_masked: assert property (p_ready_masked) else $error("ready used while disabled");

    property p_unexcited;
        ce_i && (hit[1] || hit[2] || hit[3]) |=> !motor_excite_en_o;
    endproperty
    a_unexcited: assert property (p_unexcited) else $error("motor excited on setting error");

    property p_orient_opt;
        ce_i && hit[4] && hit[3:0] == '0 |=> code_q == sci_pkg::CODE_BCD[4];
    endproperty
    a_orient_opt: assert property (p_orient_opt) else $error("code 04 missing");

    property p_contour_busy;
        ce_i && hit[10] && hit[9:0] == '0 |=> code_q == sci_pkg::CODE_BCD[10] ##1 !ce_i || mode_q != sci_pkg::MD_NORMAL || !req.contour || code_q != sci_pkg::CODE_BCD[10];
    endproperty
    a_contour_busy: assert property (p_contour_busy) else $error("code 10 wrong");

    property p_clear_when_gone;
        ce_i && hit == '0 |=> code_q == sci_pkg::CODE_NONE && !yellow_lamp_o && code_q != sci_pkg::CODE_BCD[sci_pkg::IDX_UNUSED];
    endproperty
    a_clear_when_gone: assert property (p_clear_when_gone) else $error("code not cleared");

endmodule

`default_nettype wire

//--- sim/sci_host_model.sv
// host-side model: controller and machine logic driving request pins
`timescale 1ns/1ps
`default_nettype none
module sci_host_model (
    input  wire sci_pkg::sci_req_s cmd_i,
    input  wire logic              clk_i,
    output var  sci_pkg::sci_req_s pin_o
);
    // ------------------------------------------------------------------
    // pins move one scan after the command, like a real ladder scan
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        pin_o <= cmd_i; // a held mode is dropped by the bench before another
    end
endmodule
`default_nettype wire

//--- sim/tb_sci_interlock.sv
// testbench of the spindle command interlock
`timescale 1ns/1ps
`default_nettype none
module tb_sci_interlock;
    // ------------------------------------------------------------------
    // stimulus and observation
    // ------------------------------------------------------------------
    logic clk_i = 1'b0, rst_n_i = 1'b0, yel, red, exc, irq, s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic s_axi_arready, s_axi_rvalid, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
    logic s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [7:0] alarm = 8'h00, disp, s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [1:0] s_axi_bresp, s_axi_rresp, wresp;
    logic ce = 1'b1;
    sci_pkg::sci_req_s cmd = '0, pin;
    int fails = 0, n_compared = 0;
    always #12.5 clk_i = ~clk_i;
    sci_host_model i_host (.cmd_i(cmd), .clk_i, .pin_o(pin));
    sci_interlock i_dut (.clk_i, .rst_n_i, .ce_i(ce), .emergency_stop_release_n_i(pin.esp_ok),
        .machine_ready_in_i(pin.machine_ready_in), .forward_rotation_req_i(pin.fwd), .reverse_rotation_req_i(pin.rev),
        .orientation_req_i(pin.orient), .low_speed_winding_sel_i(pin.low_wind), .contour_axis_req_i(pin.contour),
        .servo_mode_req_i(pin.servo), .spindle_sync_req_i(pin.sync), .drive_alarm_i(alarm), .display_code_o(disp),
        .yellow_lamp_o(yel), .red_lamp_o(red), .motor_excite_en_o(exc), .irq_o(irq), .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
    // ------------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic ta, tw, tb;
        @(posedge clk_i);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(negedge clk_i);
            ta = s_axi_awready & s_axi_awvalid;
            tw = s_axi_wready & s_axi_wvalid;
            tb = s_axi_bvalid;
            wresp = s_axi_bresp;
            @(posedge clk_i);
            if (ta) s_axi_awvalid <= 1'b0;
            if (tw) s_axi_wvalid <= 1'b0;
        end while (!tb);
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        logic ta, tr;
        @(posedge clk_i);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(negedge clk_i);
            ta = s_axi_arready & s_axi_arvalid;
            tr = s_axi_rvalid;
            d = s_axi_rdata;
            r = s_axi_rresp;
            @(posedge clk_i);
            if (ta) s_axi_arvalid <= 1'b0;
        end while (!tr);
        s_axi_rready <= 1'b0;
    endtask
    // one scan of the model plus two sync stages and the output register
    task automatic step(input logic [8:0] q, input logic [7:0] c);
        @(posedge clk_i);
        cmd <= q;
        repeat (4) @(posedge clk_i);
        #1;
        check(yel, c != sci_pkg::CODE_NONE);
        check(disp, (c == sci_pkg::CODE_NONE) ? 8'h00 : c);
        $display("test done at %0t", $time);
    endtask
    task automatic print_verdict();
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // ------------------------------------------------------------------
    // sequence; watchdog is far beyond the fewer than two hundred cycles needed
    // ------------------------------------------------------------------
    initial begin
        repeat (20000) @(posedge clk_i);
        fails++;
        print_verdict();
    end
    initial begin
        logic [31:0] d;
        logic [1:0] r;
        repeat (5) @(posedge clk_i);
        rst_n_i <= 1'b1;
        rd(sci_pkg::OFF_CFG_B, d, r);
        check(d, 32'h1);
        wr(sci_pkg::OFF_IRQ_MASK, 32'h1);
        check(wresp, sci_pkg::RESP_OKAY);
        step(9'h040, 8'h00);
        check(irq, 1'b1);
        rd(sci_pkg::OFF_IRQ_STAT, d, r);
        check(d[0], 1'b1);
        @(posedge clk_i);
        #1;
        check(irq, 1'b0);
        step(9'h140, sci_pkg::CODE_NONE);
        wr(sci_pkg::OFF_CFG_A, 32'h1);
        step(9'h140, 8'h00);
        step(9'h190, 8'h04);
        step(9'h188, 8'h05);
        wr(sci_pkg::OFF_OPTIONS, 32'h3);
        step(9'h198, sci_pkg::CODE_NONE);
        step(9'h184, 8'h02);
        check(exc, 1'b0);
        wr(sci_pkg::OFF_CFG_A, 32'h21);
        step(9'h184, 8'h06);
        wr(sci_pkg::OFF_CFG_B, 32'h0);
        step(9'h180, 8'h01);
        check(exc, 1'b0);
        wr(sci_pkg::OFF_CFG_B, 32'h1);
        step(9'h1c2, 8'h03);
        wr(sci_pkg::OFF_CFG_A, 32'h25);
        step(9'h182, 8'h07);
        step(9'h181, 8'h09);
        step(9'h1c4, sci_pkg::CODE_NONE);
        step(9'h1c6, 8'h10);
        step(9'h180, sci_pkg::CODE_NONE);
        step(9'h1c2, sci_pkg::CODE_NONE);
        check(exc, 1'b1);
        rd(sci_pkg::OFF_STATUS, d, r);
        check(d, 32'h0000_24ff);
        step(9'h1c3, 8'h11);
        step(9'h180, sci_pkg::CODE_NONE);
        step(9'h1a1, sci_pkg::CODE_NONE);
        step(9'h1c5, 8'h12);
        // enable low: pins move but display must stay frozen
        @(posedge clk_i);
        ce <= 1'b0;
        cmd <= 9'h180;
        repeat (6) @(posedge clk_i);
        #1;
        check(disp, 8'h12);
        check(yel, 1'b1);
        @(posedge clk_i);
        ce <= 1'b1;
        step(9'h180, sci_pkg::CODE_NONE);
        @(posedge clk_i);
        alarm <= 8'h41;
        repeat (2) @(posedge clk_i);
        #1;
        check(red, 1'b1);
        check(disp, 8'h41);
        check(yel, 1'b0);
        wr(8'h40, 32'h0);
        check(wresp, sci_pkg::RESP_SLVERR);
        rd(8'h40, d, r);
        check(r, sci_pkg::RESP_SLVERR);
        print_verdict();
    end
endmodule
`default_nettype wire
